// ---- logic/uisf_pkg.sv ----
`default_nettype none
package uisf_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_MASK = 8'h38;
   localparam logic [7:0] OFS_RAW = 8'h3C;
   localparam logic [7:0] OFS_MASKED = 8'h40;
   localparam logic [7:0] OFS_CLR = 8'h44;
   localparam logic [7:0] OFS_DMA = 8'h48;
   localparam logic [7:0] OFS_XFC = 8'h50;
   localparam logic [7:0] OFS_RES1 = 8'h54;
   localparam logic [7:0] OFS_RES2 = 8'h58;
   localparam logic [7:0] OFS_STOP1 = 8'h5C;
   localparam logic [7:0] OFS_STOP2 = 8'h60;

   // Interrupt source positions
   localparam int BIT_CTS = 1;
   localparam int BIT_RX = 4;
   localparam int BIT_TX = 5;
   localparam int BIT_RTO = 6;
   localparam int BIT_FE = 7;
   localparam int BIT_PE = 8;
   localparam int BIT_BE = 9;
   localparam int BIT_OE = 10;
   localparam int BIT_XOFF = 11;
   localparam int BIT_TXE = 12;
   localparam int IRQ_W = 13;
   localparam logic [12:0] IRQ_IMPL = 13'h1FF2;
   localparam logic [12:0] IRQ_ERR = 13'h0780;

   // DMA control fields
   localparam int DMA_RXE = 0;
   localparam int DMA_TXE = 1;
   localparam int DMA_ONERR = 3;
   localparam logic [3:0] DMA_IMPL = 4'hB;

   // Flow control fields
   localparam int XFC_EN = 0;
   localparam int XFC_RMOD_LO = 1;
   localparam int XFC_TMOD_LO = 3;
   localparam int XFC_ANY = 5;
   localparam int XFC_SPEC = 6;
   localparam int XFC_W = 7;

   // Reset values
   localparam logic [12:0] RST_IRQ = 13'h0000;
   localparam logic [3:0] RST_DMA = 4'h0;
   localparam logic [6:0] RST_XFC = 7'h00;
   localparam logic [7:0] RST_CHAR = 8'h00;

   // Flow mode encoding
   typedef enum logic [1:0] {
      FM_OFF = 2'b00,
      FM_ONE = 2'b01,
      FM_TWO = 2'b10,
      FM_BOTH = 2'b11
   } uisf_mode_e;

   // Whole register state
   typedef struct packed {
      logic [12:0] raw;
      logic [12:0] mask;
      logic [3:0] dma;
      logic [6:0] xfc;
      logic [7:0] res1;
      logic [7:0] res2;
      logic [7:0] stop1;
      logic [7:0] stop2;
      logic [31:0] rdata;
      logic irq;
   } uisf_state_s;

   // Received character event
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } uisf_char_s;

endpackage : uisf_pkg
`default_nettype wire

// ---- logic/uisf_regs.sv ----
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Raw status bit 1 shows clear-to-send pending, read-only.
// - Raw bits 4, 5, 6 show receive, transmit, receive-timeout pending.
// - Raw bits 7 to 10 show framing, parity, break, overrun pending.
// - Raw bit 11 stop-character, bit 12 transmit-empty; bits 31:13 read zero.
// - Masked status at 0x40 shows pending and enabled sources.
// - Write-only clear register at 0x44, bits 1 and 4 to 12.
// - Writing one clears pending bit; zero leaves it.
// - Receive DMA requests only while dma_control bit 0 set.
// - Transmit DMA requests only while dma_control bit 1 set.
// - Bit 3 set blocks receive DMA while any error pending.
// - Software flow control acts only when 0x50 bit 0 set; special detection (bit 6) here ignores bit 0.
// - Receive mode 2:1 selects none, pair one, pair two, both.
// - Transmit mode 4:3 uses same encoding for sent flow control.
// - Bit 5 makes any received character a resume while a receive pair is selected.
// - Special character detection only while bit 6 set.
// - First resume character at 0x54 bits 7:0, reset zero.
// - Second resume character at 0x58 bits 7:0, reset zero.
// - Mask register at 0x38 enables each source, reads back.
// - Stop characters at 0x5C and 0x60 bits 7:0.
module uisf_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt source events, one-cycle pulses
   input wire logic [12:0] irq_set,
   // Datapath DMA readiness
   input wire logic rx_dma_want,
   input wire logic tx_dma_want,
   // Received character from receiver
   input wire uisf_pkg::uisf_char_s rx_char,
   // Transmit side asks to send a flow character
   input wire logic tx_send_stop,
   input wire logic tx_send_resume,
   // Outputs
   output logic irq,
   output logic rx_dma_req,
   output logic tx_dma_req,
   output logic rx_stop_seen,
   output logic rx_resume_seen,
   output logic tx_flow_valid,
   output logic [7:0] tx_flow_char,
   output logic special_char_seen
);

   uisf_pkg::uisf_state_s s_q, s_d;
   logic acc, wr, rd, hit;
   logic [12:0] masked, clr;
   uisf_pkg::uisf_mode_e rmode, tmode;
   logic flow_on, use1r, use2r, use1t, use2t;
   logic [7:0] c;

   // APB decode; zero-wait slave, unmapped answers error
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign pready = 1'b1;
   always_comb begin
      case (paddr)
         uisf_pkg::OFS_MASK, uisf_pkg::OFS_RAW, uisf_pkg::OFS_MASKED,
         uisf_pkg::OFS_CLR, uisf_pkg::OFS_DMA, uisf_pkg::OFS_XFC,
         uisf_pkg::OFS_RES1, uisf_pkg::OFS_RES2, uisf_pkg::OFS_STOP1,
         uisf_pkg::OFS_STOP2: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = acc & ~hit;
   assign prdata = s_q.rdata;

   // Masked view and clear pulse
   assign masked = s_q.raw & s_q.mask;
   assign clr = (wr && paddr == uisf_pkg::OFS_CLR) ?
                (pwdata[12:0] & uisf_pkg::IRQ_IMPL) : 13'h0000;

   // Flow control decode
   assign flow_on = s_q.xfc[uisf_pkg::XFC_EN];
   assign rmode = uisf_pkg::uisf_mode_e'(s_q.xfc[uisf_pkg::XFC_RMOD_LO +: 2]);
   assign tmode = uisf_pkg::uisf_mode_e'(s_q.xfc[uisf_pkg::XFC_TMOD_LO +: 2]);
   // Pair selection per direction
   assign use1r = flow_on & (rmode == uisf_pkg::FM_ONE | rmode == uisf_pkg::FM_BOTH);
   assign use2r = flow_on & (rmode == uisf_pkg::FM_TWO | rmode == uisf_pkg::FM_BOTH);
   assign use1t = flow_on & (tmode == uisf_pkg::FM_ONE | tmode == uisf_pkg::FM_BOTH);
   assign use2t = flow_on & (tmode == uisf_pkg::FM_TWO | tmode == uisf_pkg::FM_BOTH);
   assign c = rx_char.data;

   // Next state
   always_comb begin
      s_d = s_q;
      // Set wins over clear so a same-cycle event is kept
      s_d.raw = ((s_q.raw & ~clr) | irq_set) & uisf_pkg::IRQ_IMPL;
      if (wr) begin
         case (paddr)
            uisf_pkg::OFS_MASK: s_d.mask = pwdata[12:0] & uisf_pkg::IRQ_IMPL;
            uisf_pkg::OFS_DMA: s_d.dma = pwdata[3:0] & uisf_pkg::DMA_IMPL;
            uisf_pkg::OFS_XFC: s_d.xfc = pwdata[6:0];
            uisf_pkg::OFS_RES1: s_d.res1 = pwdata[7:0];
            uisf_pkg::OFS_RES2: s_d.res2 = pwdata[7:0];
            uisf_pkg::OFS_STOP1: s_d.stop1 = pwdata[7:0];
            uisf_pkg::OFS_STOP2: s_d.stop2 = pwdata[7:0];
            default: s_d.xfc = s_q.xfc;
         endcase
      end
      // Read data captured at setup so it is steady in the access cycle
      s_d.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            uisf_pkg::OFS_MASK: s_d.rdata = {19'h0, s_q.mask};
            uisf_pkg::OFS_RAW: s_d.rdata = {19'h0, s_q.raw};
            uisf_pkg::OFS_MASKED: s_d.rdata = {19'h0, masked};
            uisf_pkg::OFS_DMA: s_d.rdata = {28'h0, s_q.dma};
            uisf_pkg::OFS_XFC: s_d.rdata = {25'h0, s_q.xfc};
            uisf_pkg::OFS_RES1: s_d.rdata = {24'h0, s_q.res1};
            uisf_pkg::OFS_RES2: s_d.rdata = {24'h0, s_q.res2};
            uisf_pkg::OFS_STOP1: s_d.rdata = {24'h0, s_q.stop1};
            uisf_pkg::OFS_STOP2: s_d.rdata = {24'h0, s_q.stop2};
            default: s_d.rdata = 32'h0000_0000; // Clear register reads zero
         endcase
      end
      s_d.irq = |(s_d.raw & s_d.mask);
   end

   // State register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign irq = s_q.irq;

   // DMA requests gated by enables and error blocking
   assign rx_dma_req = rx_dma_want & s_q.dma[uisf_pkg::DMA_RXE]
      & ~(s_q.dma[uisf_pkg::DMA_ONERR] & |(s_q.raw & uisf_pkg::IRQ_ERR));
   assign tx_dma_req = tx_dma_want & s_q.dma[uisf_pkg::DMA_TXE];

   // Received character matching
   assign rx_stop_seen = rx_char.valid &
      ((use1r & c == s_q.stop1) | (use2r & c == s_q.stop2));
   // Any-char resume only counts while a receive pair is active
   assign rx_resume_seen = rx_char.valid & (use1r | use2r) &
      (s_q.xfc[uisf_pkg::XFC_ANY] | (use1r & c == s_q.res1) | (use2r & c == s_q.res2));
   // Special match looks at all four programmed characters
   assign special_char_seen = rx_char.valid & s_q.xfc[uisf_pkg::XFC_SPEC] &
      (c == s_q.res1 | c == s_q.res2 | c == s_q.stop1 | c == s_q.stop2);

   // Transmitted flow character: pair one preferred when both used
   // Stop outranks resume if the transmitter asks for both at once
   assign tx_flow_valid = (tx_send_stop | tx_send_resume) & (use1t | use2t);
   assign tx_flow_char = tx_send_stop ? (use1t ? s_q.stop1 : s_q.stop2)
                                      : (use1t ? s_q.res1 : s_q.res2);

   // Checks on pending bits and their clear

   // Receive bit must drop after a lone clear
   clr_wins_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clr[uisf_pkg::BIT_RX] && !irq_set[uisf_pkg::BIT_RX]) |=> !s_q.raw[uisf_pkg::BIT_RX])
      else $error("clear did not remove pending bit");

   // An event must never be lost, even under a clear
   set_beats_clr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      irq_set[uisf_pkg::BIT_OE] |=> s_q.raw[uisf_pkg::BIT_OE])
      else $error("event lost against clear");

   // A zero in the clear word leaves the bit alone
   clr_zero_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (s_q.raw[uisf_pkg::BIT_CTS] && !clr[uisf_pkg::BIT_CTS])
      |=> s_q.raw[uisf_pkg::BIT_CTS])
      else $error("pending bit lost without clear");

   // Every implemented source latches its own event
   for (genvar i = 0; i < uisf_pkg::IRQ_W; i++) begin : g_src
      if (uisf_pkg::IRQ_IMPL[i]) begin : g_impl
         // Per-source latch check
         src_latch_a: assert property (@(posedge clk_sys) disable iff (!rstn)
            irq_set[i] |=> s_q.raw[i])
            else $error("source event not latched");
      end
   end

   // Read views of the status words

   // Masked view read back as captured at setup
   masked_view_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (psel && !penable && !pwrite && paddr == uisf_pkg::OFS_MASKED)
      |=> prdata == {19'h0, $past(s_q.raw) & $past(s_q.mask)})
      else $error("masked status read wrong");

   // Raw view read back as captured at setup
   raw_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (psel && !penable && !pwrite && paddr == uisf_pkg::OFS_RAW)
      |=> prdata == {19'h0, $past(s_q.raw)})
      else $error("raw status read wrong");

   // Upper and unused status bits stay zero
   raw_upper_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      prdata[31:13] == 19'h0 && !s_q.raw[0] && s_q.raw[3:2] == 2'b00)
      else $error("reserved status bits set");

   // Clear register is write-only and reads zero
   clr_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (psel && !penable && !pwrite && paddr == uisf_pkg::OFS_CLR) |=> prdata == 32'h0000_0000)
      else $error("clear register read not zero");

   // Mask keeps only implemented positions
   mask_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr && paddr == uisf_pkg::OFS_MASK)
      |=> s_q.mask == ($past(pwdata[12:0]) & uisf_pkg::IRQ_IMPL))
      else $error("mask not stored");

   // Mask reads back its current value
   mask_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (psel && !penable && !pwrite && paddr == uisf_pkg::OFS_MASK)
      |=> prdata == {19'h0, $past(s_q.mask)})
      else $error("mask read wrong");

   // Interrupt line follows the masked view
   irq_or_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      ##1 irq == |(s_q.raw & s_q.mask))
      else $error("interrupt not OR of masked");

   // DMA request gating

   // Receive request only with its enable
   rx_dma_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_dma_req |-> s_q.dma[uisf_pkg::DMA_RXE] && rx_dma_want)
      else $error("receive dma without enable");

   // Transmit request follows enable and want
   tx_dma_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_dma_want && s_q.dma[uisf_pkg::DMA_TXE]) |-> tx_dma_req)
      else $error("transmit dma not issued");

   // Transmit request never without its enable
   tx_dma_en_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      tx_dma_req |-> s_q.dma[uisf_pkg::DMA_TXE])
      else $error("transmit dma without enable");

   // Error blocks receive requests when asked to
   dma_err_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (s_q.dma[uisf_pkg::DMA_ONERR] && |(s_q.raw & uisf_pkg::IRQ_ERR)) |-> !rx_dma_req)
      else $error("receive dma not blocked on error");

   // Errors are ignored with blocking off
   dma_err_free_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!s_q.dma[uisf_pkg::DMA_ONERR] && rx_dma_want && s_q.dma[uisf_pkg::DMA_RXE])
      |-> rx_dma_req)
      else $error("receive dma blocked without cause");

   // Software flow control

   // Nothing flows while the enable is clear
   flow_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !s_q.xfc[uisf_pkg::XFC_EN] |-> !rx_stop_seen && !rx_resume_seen && !tx_flow_valid)
      else $error("flow control active while off");

   // Receive mode off silences both detectors
   rx_mode_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rmode == uisf_pkg::FM_OFF) |-> !rx_stop_seen && !rx_resume_seen)
      else $error("receive flow active in mode off");

   // Pair two stop character is seen in its mode
   rx_pair_two_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rx_char.valid && use2r && c == s_q.stop2) |-> rx_stop_seen)
      else $error("pair two stop missed");

   // Transmit mode off sends nothing
   tx_mode_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tmode == uisf_pkg::FM_OFF) |-> !tx_flow_valid)
      else $error("transmit flow active in mode off");

   // Pair two mode sends the second stop character
   tx_pair_two_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_flow_valid && tx_send_stop && tmode == uisf_pkg::FM_TWO) |-> tx_flow_char == s_q.stop2)
      else $error("pair two stop not sent");

   // Any character resumes when asked
   any_resume_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rx_char.valid && s_q.xfc[uisf_pkg::XFC_ANY] && (use1r || use2r)) |-> rx_resume_seen)
      else $error("any-char resume missed");

   // Without any-char only programmed values resume
   resume_match_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rx_resume_seen && !s_q.xfc[uisf_pkg::XFC_ANY]) |-> (c == s_q.res1 || c == s_q.res2))
      else $error("resume on unprogrammed character");

   // Special detection silent while off
   spec_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !s_q.xfc[uisf_pkg::XFC_SPEC] |-> !special_char_seen)
      else $error("special detect while off");

   // Special detection fires on a programmed character
   spec_on_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rx_char.valid && s_q.xfc[uisf_pkg::XFC_SPEC] && c == s_q.stop1) |-> special_char_seen)
      else $error("special character missed");

   // Character registers

   // First resume character stored on write
   xon_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr && paddr == uisf_pkg::OFS_RES1) |=> s_q.res1 == $past(pwdata[7:0]))
      else $error("resume char one not stored");

   // Second resume character stored on write
   res_two_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr && paddr == uisf_pkg::OFS_RES2) |=> s_q.res2 == $past(pwdata[7:0]))
      else $error("resume char two not stored");

   // First stop character stored on write
   stop_one_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr && paddr == uisf_pkg::OFS_STOP1) |=> s_q.stop1 == $past(pwdata[7:0]))
      else $error("stop char one not stored");

   // Second stop character stored on write
   stop_two_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wr && paddr == uisf_pkg::OFS_STOP2) |=> s_q.stop2 == $past(pwdata[7:0]))
      else $error("stop char two not stored");

   // Scenarios
   cov_clear_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      s_q.raw[uisf_pkg::BIT_RX] ##1 clr[uisf_pkg::BIT_RX]);
   cov_irq_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(irq));
   cov_block_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      rx_dma_want && s_q.dma[uisf_pkg::DMA_RXE] && !rx_dma_req);
   cov_resume_c: cover property (@(posedge clk_sys) disable iff (!rstn) rx_resume_seen);
   cov_stop_c: cover property (@(posedge clk_sys) disable iff (!rstn) rx_stop_seen);

endmodule : uisf_regs

`default_nettype wire

// ---- bench/uisf_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
// Remote peer: hands one received character to the block per request
module uisf_peer (
   // Clock and request
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [7:0] ch,
   // Character toward the block
   output uisf_pkg::uisf_char_s rx_char
);
   initial rx_char = '0;
   // Valid is one cycle; idle data flips so a stale byte never matches
   always @(posedge clk_sys) begin
      rx_char.valid <= go;
      rx_char.data <= go ? ch : ~rx_char.data;
   end
endmodule : uisf_peer
`default_nettype wire

// ---- bench/uisf_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module uisf_regs_tb;
   logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, irq, go, err;
   logic rx_dma_want, tx_dma_want, tx_send_stop, tx_send_resume, rx_dma_req, tx_dma_req;
   logic rx_stop_seen, rx_resume_seen, tx_flow_valid, special_char_seen;
   logic [7:0] paddr, ch, tx_flow_char;
   logic [31:0] pwdata, prdata, r;
   logic [12:0] irq_set;
   uisf_pkg::uisf_char_s rx_char;
   int num_errors, num_checks;

   uisf_regs DUT (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq_set, .rx_dma_want, .tx_dma_want, .rx_char, .tx_send_stop,
      .tx_send_resume, .irq, .rx_dma_req, .tx_dma_req, .rx_stop_seen, .rx_resume_seen,
      .tx_flow_valid, .tx_flow_char, .special_char_seen);
   uisf_peer peer (.clk_sys, .go, .ch, .rx_char);

   // 20 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, e);
   endtask : rd

   task automatic ev(input logic [12:0] m);
      @(posedge clk_sys);
      irq_set <= m;
      @(posedge clk_sys);
      irq_set <= 13'h0000;
   endtask : ev

   task automatic t_regs();
      for (int i = 0; i < 8; i++) rd(8'h38 + 8'(i * 4), 32'h0000_0000);
      apb(1'b0, 8'h64, 32'h0000_0000);
      chk(err, 1'b1);
      chk(r, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h54 + 8'(i * 4), 32'h0000_00A5 + i);
         rd(8'h54 + 8'(i * 4), 32'h0000_00A5 + i);
      end
      $display("register test done");
   endtask : t_regs

   task automatic t_irq();
      logic [31:0] b;
      apb(1'b1, uisf_pkg::OFS_MASK, 32'(uisf_pkg::IRQ_IMPL));
      rd(uisf_pkg::OFS_MASK, 32'h0000_1FF2);
      ev(13'h000D);
      rd(uisf_pkg::OFS_RAW, 32'h0000_0000);
      for (int i = 0; i < 13; i++) begin
         if (uisf_pkg::IRQ_IMPL[i]) begin
            b = 32'h1 << i;
            ev(b[12:0]);
            rd(uisf_pkg::OFS_RAW, b);
            rd(uisf_pkg::OFS_MASKED, b);
            chk(irq, 1'b1);
            apb(1'b1, uisf_pkg::OFS_CLR, ~b & 32'h0000_1FF2);
            rd(uisf_pkg::OFS_RAW, b);
            apb(1'b1, uisf_pkg::OFS_CLR, b);
            rd(uisf_pkg::OFS_MASKED, 32'h0000_0000);
            chk(irq, 1'b0);
         end
      end
      apb(1'b1, uisf_pkg::OFS_MASK, 32'h0000_0000);
      ev(13'h0010);
      rd(uisf_pkg::OFS_MASKED, 32'h0000_0000);
      chk(irq, 1'b0);
      apb(1'b1, uisf_pkg::OFS_CLR, 32'h0000_0010);
      $display("interrupt test done");
   endtask : t_irq

   // Write DMA control, then judge both request lines once settled
   task automatic dq(input logic [31:0] d, input logic erx, input logic etx);
      apb(1'b1, uisf_pkg::OFS_DMA, d);
      @(negedge clk_sys);
      chk(rx_dma_req, erx);
      chk(tx_dma_req, etx);
   endtask : dq

   task automatic t_dma();
      dq(32'h0000_0000, 1'b0, 1'b0);
      dq(32'h0000_0001, 1'b1, 1'b0);
      dq(32'h0000_0002, 1'b0, 1'b1);
      ev(13'h0080);
      dq(32'h0000_000B, 1'b0, 1'b1);
      dq(32'h0000_0003, 1'b1, 1'b1);
      apb(1'b1, uisf_pkg::OFS_CLR, 32'h0000_0080);
      dq(32'h0000_000B, 1'b1, 1'b1);
      $display("dma test done");
   endtask : t_dma

   // Program flow control, let the peer send one byte, judge detectors
   task automatic sc(input logic [7:0] c, input logic [6:0] x, input logic [2:0] e);
      apb(1'b1, uisf_pkg::OFS_XFC, 32'(x));
      @(posedge clk_sys);
      go <= 1'b1;
      ch <= c;
      @(posedge clk_sys);
      go <= 1'b0;
      @(negedge clk_sys);
      chk({rx_resume_seen, rx_stop_seen, special_char_seen}, e);
   endtask : sc

   task automatic t_flow();
      apb(1'b1, uisf_pkg::OFS_RES1, 32'h0000_0011);
      apb(1'b1, uisf_pkg::OFS_RES2, 32'h0000_0022);
      apb(1'b1, uisf_pkg::OFS_STOP1, 32'h0000_0013);
      for (int m = 0; m < 4; m++) sc(8'h22, 7'(1 + m * 2), {m[1], 2'b00});
      sc(8'h13, 7'h03, 3'b010);
      sc(8'h22, 7'h06, 3'b000);
      sc(8'h55, 7'h23, 3'b100);
      sc(8'h13, 7'h41, 3'b001);
      sc(8'h13, 7'h01, 3'b000);
      @(posedge clk_sys);
      tx_send_resume <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, uisf_pkg::OFS_XFC, 32'(1 + m * 8));
         @(negedge clk_sys);
         chk(tx_flow_valid, m != 0);
         if (m != 0) chk(tx_flow_char, (m == 2) ? 8'h22 : 8'h11);
      end
      // Stop characters: second stop still holds A8 from the register test
      @(posedge clk_sys);
      tx_send_resume <= 1'b0;
      tx_send_stop <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, uisf_pkg::OFS_XFC, 32'(1 + m * 8));
         @(negedge clk_sys);
         chk(tx_flow_valid, m != 0);
         if (m != 0) chk(tx_flow_char, (m == 2) ? 8'hA8 : 8'h13);
      end
      @(posedge clk_sys);
      tx_send_stop <= 1'b0;
      $display("flow control test done");
   endtask : t_flow

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   // Main sequence: quiet inputs, reset for four cycles, then scenarios
   initial begin
      {rstn, psel, penable, pwrite, go, tx_send_stop, tx_send_resume} = '0;
      {paddr, ch, pwdata, irq_set} = '0;
      {rx_dma_want, tx_dma_want} = 2'b11;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_irq();
      t_dma();
      t_flow();
      end_sim();
   end

   // Watchdog; all scenarios need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      num_errors++;
      end_sim();
   end
endmodule : uisf_regs_tb
`default_nettype wire
